// ===== hw/twb_defs.svh
// Constants for the two-wire bus master controller
// Notes on behaviour
// RULE1: Lines are only pulled low or released; released lines form a wired-AND.
// RULE2: Data line stays steady while clock is high, except for START and STOP.
// RULE3: START and STOP change the data line while the clock line is high.
// RULE4: Bus is busy from START to STOP; no new master may start then.
// RULE5: A START while owning the bus is a repeated START; bus stays busy.
// RULE6: Address packet is seven address bits, direction bit, acknowledge bit.
// RULE7: Addressed slave pulls data low in ninth cycle; unable slave leaves high.
// RULE8: After an unanswered address the master sends STOP or repeated START.
// RULE9: Address and data bytes go out most significant bit first.
// RULE10: All-zero address with write is the general call, acknowledged by slaves.
// RULE11: Never send the general call address with a read bit.
// RULE12: Addresses with upper four bits all ones are reserved.
// RULE13: Data packet is a byte plus acknowledge; low is ack, high is nack.
// RULE14: Receiver answers its final byte with a not-acknowledge.
// RULE15: Master makes clock, START and STOP; receiver makes acknowledge bits.
// RULE16: A START directly followed by a STOP is never issued.
// RULE17: Slave may hold clock low; master waits for the line to rise.
// RULE18: Master times high and low phases from the real clock line edges.
// RULE19: Master reads data back; released but low means arbitration lost.
// RULE20: Losing master releases data, goes slave, may clock to packet end. The code releases both lines and returns to ST_IDLE, with no slave mode.
// RULE21: All masters keep the same packet composition and count.
// RULE22: Bus clock rates up to 400 kHz are supported.
// RULE23: Both lines are synchronised; START and STOP found from sampled edges.
`ifndef TWB_DEFS_SVH
`define TWB_DEFS_SVH

`define TWB_CLK_MHZ     50
`define TWB_T_LOW_NS    1300
`define TWB_T_HIGH_NS   600
`define TWB_T_HOLD_NS   300
`define TWB_T_LOW_CYC   ((`TWB_T_LOW_NS * `TWB_CLK_MHZ + 999) / 1000)
`define TWB_T_HIGH_CYC  ((`TWB_T_HIGH_NS * `TWB_CLK_MHZ + 999) / 1000)
`define TWB_T_HOLD_CYC  ((`TWB_T_HOLD_NS * `TWB_CLK_MHZ + 999) / 1000)

`define TWB_FIFO_DEPTH  16
`define TWB_FIFO_WIDTH  11
`define TWB_F_OP_HI     10
`define TWB_F_OP_LO     9
`define TWB_F_NACK      8
`define TWB_GCALL_RD    8'h01
`define TWB_RSV_TOP     4'hF
`define TWB_ACK_BIT     4'h8

`endif

// ===== hw/twb_pkg.sv
// Types for the two-wire bus master controller
package twb_pkg;
  typedef enum logic [1:0] {OP_START, OP_WRITE, OP_READ, OP_STOP} twb_op_e;
  typedef enum logic [3:0] {
    ST_IDLE, ST_S_HIGH, ST_S_FALL, ST_HOLD, ST_RS_LOW, ST_S_RISE,
    ST_B_LOW, ST_B_RISE, ST_B_HIGH, ST_P_LOW, ST_P_RISE, ST_P_HIGH, ST_P_FREE
  } twb_state_e;
endpackage

// ===== hw/twb_fifo.sv
// Command FIFO in flip-flops
`timescale 1ns/1ps
module twb_fifo #(
  parameter int W = 11,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         ce,
  input  wire logic         reset_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_reg [D];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0]   cnt_reg, cnt_next;
  logic          push, pop;

  assign in_ready  = (cnt_reg != (AW+1)'(D));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rp_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wp_next  = push ? ((wp_reg == AW'(D-1)) ? '0 : wp_reg + 1'b1) : wp_reg;
    rp_next  = pop ? ((rp_reg == AW'(D-1)) ? '0 : rp_reg + 1'b1) : rp_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else if (ce) begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage has no reset; out_data shows the entry at the read pointer, which holds written data only while out_valid is high
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem_reg[wp_reg] <= in_data;
    end
  end
endmodule

// ===== hw/twb_master.sv
// Two-wire bus master: drives clock and data lines from a queued command stream
`timescale 1ns/1ps
`include "twb_defs.svh"
module twb_master
  import twb_pkg::*;
#(
  parameter int FIFO_DEPTH = `TWB_FIFO_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       ce,
  input  wire logic       reset_n,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire twb_op_e    cmd_op,
  input  wire logic       cmd_nack,
  input  wire logic [7:0] cmd_data,
  output logic            done,
  output logic            ack_seen,
  output logic [7:0]      rx_data,
  output logic            cmd_err,
  output logic            arb_lost,
  output logic            bus_busy,
  output logic            bus_owned,
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe
);
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [7:0] T_LOW_C  = 8'(`TWB_T_LOW_CYC);   // [RULE22]
  localparam logic [7:0] T_HIGH_C = 8'(`TWB_T_HIGH_CYC);  // [RULE22]
  localparam logic [7:0] T_HOLD_C = 8'(`TWB_T_HOLD_CYC);
  localparam int         T_LOW_I  = `TWB_T_LOW_CYC;

  // ----------------------------------------------------------------
  // Command queue
  // ----------------------------------------------------------------
  logic [`TWB_FIFO_WIDTH-1:0] f_data;
  logic                       f_valid;
  logic                       pop;
  twb_op_e                    f_op;
  logic [7:0]                 f_byte;

  twb_fifo #(.W(`TWB_FIFO_WIDTH), .D(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .ce        (ce),
    .reset_n   (reset_n),
    .in_valid  (cmd_valid),
    .in_ready  (cmd_ready),
    .in_data   ({cmd_op, cmd_nack, cmd_data}),
    .out_valid (f_valid),
    .out_ready (pop),
    .out_data  (f_data)
  );
  assign f_op   = twb_op_e'(f_data[`TWB_F_OP_HI:`TWB_F_OP_LO]);
  assign f_byte = f_data[7:0];

  // ----------------------------------------------------------------
  // Line synchronisers and bus condition detection
  // ----------------------------------------------------------------
  logic scl_m, scl_s, sda_m, sda_s, sda_p;
  logic busy_reg, busy_next;
  logic start_det, stop_det;

  assign start_det = scl_s && sda_p && !sda_s;  // [RULE23] [RULE3]
  assign stop_det  = scl_s && !sda_p && sda_s;  // [RULE23] [RULE3]

  always_comb begin
    busy_next = busy_reg;
    if (stop_det) busy_next = 1'b0;
    if (start_det) busy_next = 1'b1;  // [RULE4] [RULE5]
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scl_m    <= 1'b1;
      scl_s    <= 1'b1;
      sda_m    <= 1'b1;
      sda_s    <= 1'b1;
      sda_p    <= 1'b1;
      busy_reg <= 1'b0;
    end else if (ce) begin
      scl_m    <= scl_i;
      scl_s    <= scl_m;
      sda_m    <= sda_i;
      sda_s    <= sda_m;
      sda_p    <= sda_s;
      busy_reg <= busy_next;
    end
  end

  // ----------------------------------------------------------------
  // Bit engine
  // ----------------------------------------------------------------
  twb_state_e st_reg, st_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] sh_reg, sh_next;
  logic       rd_reg, rd_next, nack_reg, nack_next;
  logic       aft_reg, aft_next, apend_reg, apend_next;
  logic       own_reg, own_next;
  logic       scl_oe_reg, scl_oe_next, sda_oe_reg, sda_oe_next;
  logic       done_reg, done_next, ack_reg, ack_next;
  logic [7:0] rx_reg, rx_next;
  logic       err_reg, err_next, arb_reg, arb_next;
  logic       arb_hit, bad_addr;

  // Only bits this master transmits can lose arbitration
  assign arb_hit  = (st_reg == ST_B_HIGH) && (cnt_reg == '0) && !rd_reg
                    && (bit_reg != `TWB_ACK_BIT) && !sda_oe_reg && !sda_s;  // [RULE19]
  assign bad_addr = (f_byte == `TWB_GCALL_RD)                               // [RULE11]
                    || (f_byte[7:4] == `TWB_RSV_TOP);                       // [RULE12]
  assign pop = f_valid && ((st_reg == ST_HOLD)
               || (st_reg == ST_IDLE && (f_op != OP_START || !busy_reg)));  // [RULE4]

  always_comb begin
    st_next     = st_reg;
    cnt_next    = cnt_reg + 8'h01;
    bit_next    = bit_reg;
    sh_next     = sh_reg;
    rd_next     = rd_reg;
    nack_next   = nack_reg;
    aft_next    = aft_reg;
    apend_next  = apend_reg;
    own_next    = own_reg;
    scl_oe_next = scl_oe_reg;
    sda_oe_next = sda_oe_reg;
    done_next   = 1'b0;
    ack_next    = ack_reg;
    rx_next     = rx_reg;
    err_next    = 1'b0;
    arb_next    = 1'b0;
    case (st_reg)
      ST_IDLE: begin
        cnt_next = '0;
        if (pop) begin
          if (f_op == OP_START) begin
            st_next  = ST_S_HIGH;
            own_next = 1'b1;
          end else begin
            err_next = 1'b1;
          end
        end
      end
      ST_S_HIGH: begin
        if (cnt_reg == T_HIGH_C - 8'h01) begin
          st_next     = ST_S_FALL;
          cnt_next    = '0;
          sda_oe_next = 1'b1;  // [RULE3]
        end
      end
      ST_S_FALL: begin
        if (cnt_reg == T_HIGH_C - 8'h01) begin
          st_next     = ST_HOLD;
          scl_oe_next = 1'b1;  // [RULE15]
          aft_next    = 1'b1;
          apend_next  = 1'b1;
        end
      end
      ST_HOLD: begin
        cnt_next = '0;
        if (pop) begin
          case (f_op)
            OP_START: st_next = ST_RS_LOW;  // [RULE5] [RULE8]
            OP_STOP: begin
              if (aft_reg) err_next = 1'b1;  // [RULE16]
              else st_next = ST_P_LOW;       // [RULE8]
            end
            OP_WRITE: begin
              if (apend_reg && bad_addr) begin
                err_next = 1'b1;
              end else begin
                st_next    = ST_B_LOW;
                sh_next    = f_byte;  // [RULE6]
                rd_next    = 1'b0;
                bit_next   = '0;
                apend_next = 1'b0;
                aft_next   = 1'b0;
              end
            end
            OP_READ: begin
              if (apend_reg) begin
                err_next = 1'b1;
              end else begin
                st_next   = ST_B_LOW;
                rd_next   = 1'b1;
                nack_next = f_data[`TWB_F_NACK];  // [RULE14]
                bit_next  = '0;
              end
            end
            default: err_next = 1'b1;
          endcase
        end
      end
      ST_RS_LOW: begin
        if (cnt_reg == T_HOLD_C) sda_oe_next = 1'b0;
        if (cnt_reg == T_LOW_C - 8'h01) begin
          st_next     = ST_S_RISE;
          scl_oe_next = 1'b0;
        end
      end
      ST_S_RISE: begin
        cnt_next = '0;
        if (scl_s) st_next = ST_S_HIGH;  // [RULE17]
      end
      ST_B_LOW: begin
        if (cnt_reg == T_HOLD_C) begin
          if (bit_reg == `TWB_ACK_BIT) sda_oe_next = rd_reg && !nack_reg;  // [RULE13] [RULE14]
          else sda_oe_next = !rd_reg && !sh_reg[7];  // [RULE9] [RULE1]
        end
        if (cnt_reg == T_LOW_C - 8'h01) begin
          st_next     = ST_B_RISE;
          scl_oe_next = 1'b0;
        end
      end
      ST_B_RISE: begin
        cnt_next = '0;
        if (scl_s) st_next = ST_B_HIGH;  // [RULE17] [RULE18]
      end
      ST_B_HIGH: begin
        if (arb_hit) begin
          st_next     = ST_IDLE;  // [RULE19] [RULE20]
          scl_oe_next = 1'b0;
          sda_oe_next = 1'b0;
          own_next    = 1'b0;
          arb_next    = 1'b1;
        end else begin
          if (cnt_reg == '0) begin
            if (bit_reg == `TWB_ACK_BIT) begin
              if (!rd_reg) ack_next = !sda_s;  // [RULE7] [RULE10] [RULE13]
            end else if (rd_reg) begin
              sh_next = {sh_reg[6:0], sda_s};  // [RULE9]
            end
          end
          // Another master pulling the clock low ends the phase early
          if (cnt_reg == T_HIGH_C - 8'h01 || (cnt_reg != '0 && !scl_s)) begin  // [RULE18]
            cnt_next    = '0;
            scl_oe_next = 1'b1;
            if (bit_reg == `TWB_ACK_BIT) begin
              st_next   = ST_HOLD;
              done_next = 1'b1;
              rx_next   = sh_reg;
              if (rd_reg) ack_next = !nack_reg;
            end else begin
              st_next  = ST_B_LOW;
              bit_next = bit_reg + 4'h1;
              if (!rd_reg) sh_next = {sh_reg[6:0], 1'b0};
            end
          end
        end
      end
      ST_P_LOW: begin
        if (cnt_reg == T_HOLD_C) sda_oe_next = 1'b1;
        if (cnt_reg == T_LOW_C - 8'h01) begin
          st_next     = ST_P_RISE;
          scl_oe_next = 1'b0;
        end
      end
      ST_P_RISE: begin
        cnt_next = '0;
        if (scl_s) st_next = ST_P_HIGH;  // [RULE17]
      end
      ST_P_HIGH: begin
        if (cnt_reg == T_HIGH_C - 8'h01) begin
          st_next     = ST_P_FREE;
          cnt_next    = '0;
          sda_oe_next = 1'b0;  // [RULE3]
        end
      end
      ST_P_FREE: begin
        if (cnt_reg == T_LOW_C - 8'h01) begin
          st_next  = ST_IDLE;
          own_next = 1'b0;
        end
      end
      default: st_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_reg     <= ST_IDLE;
      cnt_reg    <= '0;
      bit_reg    <= '0;
      sh_reg     <= '0;
      rd_reg     <= 1'b0;
      nack_reg   <= 1'b0;
      aft_reg    <= 1'b0;
      apend_reg  <= 1'b0;
      own_reg    <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      done_reg   <= 1'b0;
      ack_reg    <= 1'b0;
      rx_reg     <= '0;
      err_reg    <= 1'b0;
      arb_reg    <= 1'b0;
    end else if (ce) begin
      st_reg     <= st_next;
      cnt_reg    <= cnt_next;
      bit_reg    <= bit_next;
      sh_reg     <= sh_next;
      rd_reg     <= rd_next;
      nack_reg   <= nack_next;
      aft_reg    <= aft_next;
      apend_reg  <= apend_next;
      own_reg    <= own_next;
      scl_oe_reg <= scl_oe_next;
      sda_oe_reg <= sda_oe_next;
      done_reg   <= done_next;
      ack_reg    <= ack_next;
      rx_reg     <= rx_next;
      err_reg    <= err_next;
      arb_reg    <= arb_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign scl_o     = 1'b0;  // [RULE1]
  assign sda_o     = 1'b0;  // [RULE1]
  assign scl_oe    = scl_oe_reg;
  assign sda_oe    = sda_oe_reg;
  assign done      = done_reg;
  assign ack_seen  = ack_reg;
  assign rx_data   = rx_reg;
  assign cmd_err   = err_reg;
  assign arb_lost  = arb_reg;
  assign bus_busy  = busy_reg;
  assign bus_owned = own_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk iff ce); endclocking
  default disable iff (!reset_n);

  sequence s_free_hold;
    (st_reg == ST_P_FREE && !sda_oe_reg && !scl_oe_reg)[*4];
  endsequence

  drive_low_only_a: assert property (scl_o == 1'b0 && sda_o == 1'b0)  // [RULE1]
    else $error("line driven high");
  sda_steady_a: assert property (($changed(sda_oe_reg) && !scl_oe_reg && !$past(scl_oe_reg))  // [RULE2]
      |-> (st_reg == ST_S_FALL || st_reg == ST_P_FREE))
    else $error("data moved while clock high");
  stop_tail_a: assert property ($rose(st_reg == ST_P_FREE) |-> s_free_hold)  // [RULE3]
    else $error("stop not held released");
  start_when_free_a: assert property ((st_reg == ST_IDLE && st_next == ST_S_HIGH) |-> !busy_reg)  // [RULE4]
    else $error("start on busy bus");
  no_empty_msg_a: assert property ((st_reg == ST_HOLD && st_next == ST_P_LOW) |-> !aft_reg)  // [RULE16]
    else $error("stop right after start");
  msb_first_a: assert property ((st_reg == ST_B_HIGH && !rd_reg && bit_reg != `TWB_ACK_BIT)  // [RULE9]
      |-> sda_oe_reg == !sh_reg[7])
    else $error("wrong data bit on line");
  final_nack_a: assert property ((st_reg == ST_B_HIGH && rd_reg && bit_reg == `TWB_ACK_BIT)  // [RULE14]
      |-> sda_oe_reg == !nack_reg)
    else $error("acknowledge level wrong");
  arb_release_a: assert property (arb_hit |=> (arb_lost && !sda_oe && !scl_oe && !bus_owned)  // [RULE19]
      ##1 !arb_lost)
    else $error("arbitration loss not handled");
  stretch_wait_a: assert property ((st_reg == ST_B_RISE && !scl_s) |=> st_reg == ST_B_RISE)  // [RULE17]
    else $error("did not wait for clock rise");
  low_time_a: assert property ($rose(st_reg == ST_B_RISE) |-> $past(cnt_reg) == 8'(T_LOW_I - 1))  // [RULE18]
    else $error("low phase length wrong");
endmodule

// ===== sim/twb_slave_model.sv
// Behavioural slave on the shared two-wire bus, with clock stretching
`timescale 1ns/1ps
module twb_slave_model #(
  parameter logic [6:0] ADDR    = 7'h2A,
  parameter logic [7:0] RD_DATA = 8'h3C
) (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       stretch,
  output logic            scl_pull,
  output logic            sda_pull,
  output logic [7:0]      last_rx,
  output int              n_rx
);
  // ----------------------------------------
  // Bit-level responder
  // ----------------------------------------
  logic [1:0] phase;
  logic [7:0] shr;
  logic [7:0] tx;
  logic       mack;
  logic       hit;
  int         cnt;

  assign hit = (shr[7:1] == ADDR) || (shr == 8'h00);

  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    phase = 2'h0;
    cnt = 0;
    n_rx = 0;
    last_rx = 8'h00;
    shr = 8'h00;
    tx = RD_DATA;
    mack = 1'b0;
  end

  // The clock fall right after a START is not a bit
  always @(negedge sda) if (scl === 1'b1) begin
    phase = 2'h1;
    cnt = -1;
    sda_pull = 1'b0;
  end

  always @(posedge sda) if (scl === 1'b1) phase = 2'h0;

  always @(posedge scl) begin
    if (phase != 2'h0 && cnt >= 0 && cnt < 8) shr = {shr[6:0], sda};
    if (phase == 2'h3 && cnt == 8) mack = ~sda;
  end

  // Lines change only while the clock is low
  always @(negedge scl) if (phase != 2'h0) begin
    cnt = cnt + 1;
    sda_pull = 1'b0;
    if (cnt == 8 && phase == 2'h1) sda_pull = hit;
    if (cnt == 8 && phase == 2'h2) begin
      sda_pull = 1'b1;
      last_rx = shr;
      n_rx++;
    end
    if (cnt == 9) begin
      cnt = 0;
      if (phase == 2'h1) begin
        phase = !hit ? 2'h0 : (shr[0] ? 2'h3 : 2'h2);
        tx = RD_DATA;
      end else if (phase == 2'h3 && mack) begin
        tx = tx + 8'h01;
      end else if (phase == 2'h3) begin
        phase = 2'h0;
      end
    end
    if (phase == 2'h3 && cnt < 8) sda_pull = ~tx[7 - cnt];
  end

  // Stretch every low phase to 2 us when asked
  always @(negedge scl) if (stretch) begin
    scl_pull = 1'b1;
    #2000;
    scl_pull = 1'b0;
  end
endmodule

// ===== sim/tb_top.sv
// Self-checking bench for the two-wire bus master
`timescale 1ns/1ps
module tb_top;
  import twb_pkg::*;
  localparam logic [6:0] ADDR = 7'h2A;
  logic       clk = 1'b0;
  logic       ce = 1'b1;
  logic       reset_n = 1'b0;
  logic       cmd_valid = 1'b0;
  logic       cmd_nack = 1'b0;
  logic       stretch = 1'b0;
  logic       rival = 1'b0;
  twb_op_e    cmd_op = OP_START;
  logic [7:0] cmd_data = 8'h00;
  logic [7:0] rx_data;
  logic [7:0] last_rx;
  logic       cmd_ready, done, ack_seen, cmd_err, arb_lost, bus_busy, bus_owned;
  logic       scl_o, scl_oe, sda_o, sda_oe, scl_pull, sda_pull, scl, sda;
  int         n_fail = 0, compares = 0, n_err = 0, n_arb = 0, n_full = 0, n_rx, cyc = 0;
  logic       acks[$];
  logic [7:0] rxs[$];

  assign scl = ~(scl_oe | scl_pull);
  assign sda = ~(sda_oe | sda_pull | rival);
  always #10 clk = ~clk;

  twb_master u_dut (.clk(clk), .ce(ce), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_nack(cmd_nack), .cmd_data(cmd_data), .done(done), .ack_seen(ack_seen),
    .rx_data(rx_data), .cmd_err(cmd_err), .arb_lost(arb_lost), .bus_busy(bus_busy), .bus_owned(bus_owned),
    .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
  twb_slave_model #(.ADDR(ADDR), .RD_DATA(8'h3C)) u_slave (.scl(scl), .sda(sda), .stretch(stretch),
    .scl_pull(scl_pull), .sda_pull(sda_pull), .last_rx(last_rx), .n_rx(n_rx));

  // ----------------------------------------
  // Checking and bus helpers
  // ----------------------------------------
  task automatic complete_run;
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_num(input int got, input int exp);
    compares++;
    if (got != exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Results are sampled at the falling edge, where the pulses have settled
  always @(negedge clk) begin
    cyc++;
    if (done === 1'b1) begin
      acks.push_back(ack_seen);
      rxs.push_back(rx_data);
    end
    if (cmd_err === 1'b1) n_err++;
    if (arb_lost === 1'b1) n_arb++;
    if (cmd_ready === 1'b0 && reset_n) n_full++;
    if (cyc == 80000) begin
      n_fail++;
      complete_run();
    end
  end

  // Called at a falling edge; valid stays up for a following push
  task automatic push(input twb_op_e op, input logic [7:0] d, input logic nk = 1'b0);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_data = d;
    cmd_nack = nk;
    while (cmd_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
  endtask

  task automatic run_msg;
    cmd_valid = 1'b0;
    // Ownership starts at the pop; busy follows only once the START is on the lines
    while (bus_owned !== 1'b1 || scl_oe !== 1'b1) @(negedge clk);
    chk_bit(bus_busy, 1'b1);
    while (bus_owned !== 1'b0) @(negedge clk);
    repeat (8) @(negedge clk);
    chk_bit(bus_busy, 1'b0);
    chk_bit(scl & sda, 1'b1);
  endtask

  task automatic fresh;
    acks.delete();
    rxs.delete();
    n_err = 0;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_write;
    fresh();
    push(OP_START, 8'h00);
    push(OP_WRITE, {ADDR, 1'b0});
    push(OP_WRITE, 8'hA5);
    push(OP_STOP, 8'h00);
    run_msg();
    chk_num(acks.size(), 2);
    chk_bit(acks[0], 1'b1);
    chk_bit(acks[1], 1'b1);
    chk_byte(last_rx, 8'hA5);
  endtask

  task automatic t_read;
    fresh();
    push(OP_START, 8'h00);
    push(OP_WRITE, {ADDR, 1'b0});
    push(OP_START, 8'h00);
    push(OP_WRITE, {ADDR, 1'b1});
    push(OP_READ, 8'h00, 1'b0);
    push(OP_READ, 8'h00, 1'b1);
    push(OP_STOP, 8'h00);
    run_msg();
    chk_num(acks.size(), 4);
    chk_bit(acks[1], 1'b1);
    chk_bit(acks[2], 1'b1);
    chk_bit(acks[3], 1'b0);
    chk_byte(rxs[2], 8'h3C);
    chk_byte(rxs[3], 8'h3D);
  endtask

  task automatic t_nack;
    fresh();
    push(OP_START, 8'h00);
    push(OP_WRITE, {7'h77, 1'b0});
    push(OP_STOP, 8'h00);
    run_msg();
    chk_num(acks.size(), 1);
    chk_bit(acks[0], 1'b0);
  endtask

  task automatic t_gcall;
    logic [2:0] held;
    fresh();
    push(OP_START, 8'h00);
    push(OP_WRITE, 8'h00);
    push(OP_WRITE, 8'h5A);
    push(OP_STOP, 8'h00);
    cmd_valid = 1'b0;
    // Freeze inside the address byte; longer than one bit, so a live engine would move
    repeat (300) @(negedge clk);
    ce = 1'b0;
    held = {scl_oe, sda_oe, bus_owned};
    for (int i = 0; i < 120; i++) begin
      @(negedge clk);
      chk_byte({5'h00, scl_oe, sda_oe, bus_owned}, {5'h00, held});
    end
    ce = 1'b1;
    run_msg();
    chk_bit(acks[0], 1'b1);
    chk_byte(last_rx, 8'h5A);
  endtask

  task automatic t_refuse;
    fresh();
    push(OP_WRITE, 8'h12);
    push(OP_START, 8'h00);
    push(OP_STOP, 8'h00);
    push(OP_WRITE, 8'h01);
    push(OP_WRITE, 8'hF0);
    push(OP_READ, 8'h00);
    push(OP_WRITE, {ADDR, 1'b0});
    push(OP_WRITE, 8'h33);
    push(OP_STOP, 8'h00);
    run_msg();
    chk_num(n_err, 5);
    chk_num(acks.size(), 2);
    chk_byte(last_rx, 8'h33);
  endtask

  task automatic t_fifo;
    int base;
    fresh();
    base = n_rx;
    n_full = 0;
    stretch = 1'b1;
    push(OP_START, 8'h00);
    push(OP_WRITE, {ADDR, 1'b0});
    for (int i = 0; i < 15; i++) push(OP_WRITE, 8'h10 + 8'(i));
    push(OP_STOP, 8'h00);
    run_msg();
    stretch = 1'b0;
    chk_bit(n_full > 0, 1'b1);
    chk_num(acks.size(), 16);
    chk_num(n_rx - base, 15);
    chk_byte(last_rx, 8'h1E);
  endtask

  task automatic t_arb;
    fresh();
    push(OP_START, 8'h00);
    push(OP_WRITE, {ADDR, 1'b0});
    push(OP_WRITE, 8'hFF);
    push(OP_STOP, 8'h00);
    cmd_valid = 1'b0;
    while (acks.size() == 0) @(negedge clk);
    rival = 1'b1;
    while (n_arb == 0) @(negedge clk);
    repeat (4) @(negedge clk);
    chk_num(n_arb, 1);
    chk_bit(sda_oe | scl_oe, 1'b0);
    chk_bit(bus_owned, 1'b0);
    chk_bit(bus_busy, 1'b1);
    rival = 1'b0;
    repeat (8) @(negedge clk);
    chk_bit(bus_busy, 1'b0);
  endtask

  initial begin
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    chk_bit(cmd_ready, 1'b1);
    chk_bit(bus_owned | scl_oe | sda_oe, 1'b0);
    chk_bit(scl_o | sda_o, 1'b0);
    t_write();
    t_read();
    t_nack();
    t_gcall();
    t_refuse();
    t_fifo();
    t_arb();
    complete_run();
  end
endmodule
